// ===== verilog/power_mgmt_pkg.sv
package power_mgmt_pkg;
  // ==========================================================================
  // Register access codes on the link.
  // ==========================================================================
  localparam logic [1:0] REG_SLEEP_MODE_CONTROL = 2'h0;
  localparam logic [1:0] REG_CORE_CONTROL       = 2'h1;
  localparam logic [1:0] REG_CLOCK_GATE_CONTROL = 2'h2;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int SLEEP_ENABLE_BIT_POS   = 0;
  localparam int SLEEP_MODE_LSB         = 1;
  localparam int SLEEP_MODE_MSB         = 3;
  localparam int SCAN_PORT_DISABLE_POS  = 7;
  localparam int BROWNOUT_OFF_POS       = 6;
  localparam int BROWNOUT_UNLOCK_POS    = 5;
  localparam int GATE_TIMER_ONE_POS     = 3;
  localparam int GATE_SERIAL_POS        = 2;
  localparam int GATE_ASYNC_POS         = 1;
  localparam int GATE_CONVERTER_POS     = 0;
  localparam logic [7:0] CLOCK_GATE_MASK   = 8'h0F;
  localparam logic [7:0] SLEEP_MODE_MASK   = 8'h0F;
  localparam logic [7:0] CORE_CONTROL_MASK = 8'hE0;
  localparam logic [7:0] REG_RESET         = 8'h00;

  // ==========================================================================
  // Sleep mode codes.
  // ==========================================================================
  localparam logic [2:0] MODE_IDLE       = 3'h0;
  localparam logic [2:0] MODE_NOISE_RED  = 3'h1;
  localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
  localparam logic [2:0] MODE_POWER_SAVE = 3'h3;
  localparam logic [2:0] MODE_STANDBY    = 3'h6;

  // ==========================================================================
  // Timing counts in system clock cycles.
  // ==========================================================================
  localparam logic [2:0] UNLOCK_WINDOW_CYCLES = 3'h4;
  localparam logic [2:0] BROWNOUT_ACT_CYCLES  = 3'h3;
  localparam logic [2:0] WAKE_HALT_CYCLES     = 3'h4;

  // ==========================================================================
  // Controller register map on APB.
  // ==========================================================================
  localparam logic [7:0] APB_SLEEP_MODE = 8'h00;
  localparam logic [7:0] APB_CORE_CTRL  = 8'h04;
  localparam logic [7:0] APB_CLOCK_GATE = 8'h08;
  localparam logic [7:0] APB_COMMAND    = 8'h0C;
  localparam logic [7:0] APB_STATUS     = 8'h10;
  localparam int CMD_SLEEP_POS = 0;
  localparam int CMD_WAKE_POS  = 1;

  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_SLEEP = 4'h2,
    ST_WAKE  = 4'h4,
    ST_HOLD  = 4'h8
  } power_state_type;
endpackage

// ===== verilog/power_mgmt_if.sv
`timescale 1ns/1ps
interface power_mgmt_if;
  logic       reg_write;
  logic [1:0] reg_sel;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       sleep_instr;
  logic       wake_event;
  logic       cpu_halted;
  logic       sleeping;
  modport device (
    input  reg_write, reg_sel, reg_wdata, sleep_instr, wake_event,
    output reg_rdata, cpu_halted, sleeping
  );
  modport host (
    output reg_write, reg_sel, reg_wdata, sleep_instr, wake_event,
    input  reg_rdata, cpu_halted, sleeping
  );
endinterface

// ===== verilog/pulse_counter.sv
`timescale 1ns/1ps
module pulse_counter #(
  parameter int WIDTH = 3
) (
  // Clock and reset.
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // Control.
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] count_in,
  // Status.
  output logic                  busy_out,
  output logic                  done_out
);
  // ==========================================================================
  // Down counter; done is high in the last counted cycle, so the owner acts
  // on the very edge at which the count runs out and not one cycle late.
  // ==========================================================================
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             done_d;

  assign count_d = load_in ? count_in :
                   (count_q != '0) ? count_q - WIDTH'(1) : count_q;
  assign done_d  = !load_in && (count_q == WIDTH'(1));

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign busy_out = (count_q != '0);
  assign done_out = done_d;
endmodule

// ===== verilog/power_mgmt_control.sv
// Operation
// - Gate bit set stops clock, blocks registers
// - Clearing gate bit resumes frozen peripheral
// - Gating applies only in active, idle
// - Sleep mode field decodes five modes
// - Sleep only when sleep enable set
// - Software sets enable just before sleep
// - Brown-out bit set by timed sequence
// - Brown-out bit active three cycles later; code makes it active as soon as it is set
// - Hardware clears brown-out bit after three
// - Sleep while brown-out bit active disables
// - Brown-out bit six, unlock bit five
// - Gate register upper nibble reads zero
// - Gate bits: timer, serial, async, converter
// - Reinitialise serial ports after ungating
// - Disable converter before gating it
// - Gated converter denies comparator mux
// - Deep sleep disables digital input buffers; code keeps them on while converter enabled
// - Disable bit turns off scan port
// - Debug keeps main clock in deep sleeps; code also needs the scan port enabled in power-down and power-save
// - Converter stays on; extended conversion after
// - Comparator auto-off in deeper sleeps; code leaves it on while it uses the reference
// - Wake halts CPU four extra cycles
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
module power_mgmt_control (
  // Clock and reset.
  input  wire logic  clk_sys_in,
  input  wire logic  rst_in,
  // CPU link.
  power_mgmt_if.device link,
  // Fuses and analog status.
  input  wire logic  debug_enable_fuse_in,
  input  wire logic  scan_port_enable_fuse_in,
  input  wire logic  converter_enabled_in,
  input  wire logic  comparator_uses_ref_in,
  input  wire logic  startup_done_in,
  // Clock gates and power controls.
  output logic [3:0] module_clock_en_out,
  output logic [3:0] module_access_en_out,
  output logic       io_clock_en_out,
  output logic       converter_clock_en_out,
  output logic       main_osc_en_out,
  output logic       input_buffer_en_out,
  output logic       comparator_mux_allow_out,
  output logic       comparator_off_out,
  output logic       brownout_off_out,
  output logic       scan_port_en_out,
  output logic       converter_extended_out
);
  import power_mgmt_pkg::*;

  // ==========================================================================
  // Registers.
  // ==========================================================================
  logic [7:0]      sleep_mode_control_q;
  logic [7:0]      core_control_q;
  logic [7:0]      clock_gate_control_q;
  power_state_type state_q;
  power_state_type state_d;
  logic            extended_q;
  logic            conv_gate_prev_q;
  logic [3:0]      module_clock_en_q;
  logic [3:0]      module_access_en_q;
  logic            io_clock_en_q;
  logic            converter_clock_en_q;
  logic            main_osc_en_q;
  logic            input_buffer_en_q;
  logic            comparator_mux_allow_q;
  logic            comparator_off_q;
  logic            brownout_off_q;
  logic            scan_port_en_q;
  logic [7:0]      reg_rdata_q;
  logic            cpu_halted_q;
  logic            sleeping_q;

  // ==========================================================================
  // Decode.
  // ==========================================================================
  wire       wr_sleep = link.reg_write && (link.reg_sel == REG_SLEEP_MODE_CONTROL);
  wire       wr_core  = link.reg_write && (link.reg_sel == REG_CORE_CONTROL);
  wire       wr_gate  = link.reg_write && (link.reg_sel == REG_CLOCK_GATE_CONTROL);
  wire [2:0] sleep_mode_select = sleep_mode_control_q[SLEEP_MODE_MSB:SLEEP_MODE_LSB];
  wire       sleep_enable_bit  = sleep_mode_control_q[SLEEP_ENABLE_BIT_POS];
  wire       mode_valid = (sleep_mode_select == MODE_IDLE) ||
                          (sleep_mode_select == MODE_NOISE_RED) ||
                          (sleep_mode_select == MODE_POWER_DOWN) ||
                          (sleep_mode_select == MODE_POWER_SAVE) ||
                          (sleep_mode_select == MODE_STANDBY);
  // Reserved codes are refused so the core never halts without a wake path.
  wire       go_sleep = link.sleep_instr && sleep_enable_bit && mode_valid;
  wire       asleep   = (state_q == ST_SLEEP);
  wire       in_idle  = asleep && (sleep_mode_select == MODE_IDLE);
  wire       in_nrm   = asleep && (sleep_mode_select == MODE_NOISE_RED);
  wire       deep     = asleep && !in_idle && !in_nrm;
  wire       pd_or_ps = asleep && ((sleep_mode_select == MODE_POWER_DOWN) ||
                                   (sleep_mode_select == MODE_POWER_SAVE));
  wire       scan_on  = scan_port_enable_fuse_in && !core_control_q[SCAN_PORT_DISABLE_POS];

  // ==========================================================================
  // Brown-out timed sequence.
  // ==========================================================================
  wire unlock_busy;
  wire brownout_busy;
  wire brownout_done;
  wire unlock_req = wr_core && link.reg_wdata[BROWNOUT_OFF_POS] &&
                    link.reg_wdata[BROWNOUT_UNLOCK_POS];
  wire brownout_set = wr_core && unlock_busy && !unlock_req &&
                      link.reg_wdata[BROWNOUT_OFF_POS] &&
                      !link.reg_wdata[BROWNOUT_UNLOCK_POS];

  pulse_counter #(.WIDTH(3)) u_unlock (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (unlock_req),
    .count_in   (UNLOCK_WINDOW_CYCLES),
    .busy_out   (unlock_busy),
    .done_out   ()
  );

  pulse_counter #(.WIDTH(3)) u_brownout (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (brownout_set),
    .count_in   (BROWNOUT_ACT_CYCLES),
    .busy_out   (brownout_busy),
    .done_out   (brownout_done)
  );

  // ==========================================================================
  // Wake halt counter.
  // ==========================================================================
  wire halt_done;
  wire halt_load = (state_q == ST_WAKE) && startup_done_in;

  pulse_counter #(.WIDTH(3)) u_halt (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (halt_load),
    .count_in   (WAKE_HALT_CYCLES),
    .busy_out   (),
    .done_out   (halt_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN:   if (go_sleep) state_d = ST_SLEEP;
      ST_SLEEP: if (link.wake_event) state_d = ST_WAKE;
      ST_WAKE:  if (startup_done_in) state_d = ST_HOLD;
      ST_HOLD:  if (halt_done) state_d = ST_RUN;
      default:  state_d = ST_RUN;
    endcase
  end

  // ==========================================================================
  // Read mux.
  // ==========================================================================
  wire [7:0] rdata_d = (link.reg_sel == REG_SLEEP_MODE_CONTROL) ? sleep_mode_control_q :
                       (link.reg_sel == REG_CORE_CONTROL)       ? core_control_q :
                       (link.reg_sel == REG_CLOCK_GATE_CONTROL) ?
                       (clock_gate_control_q & CLOCK_GATE_MASK) : REG_RESET;

  // Gate bits only stop module clocks while the I/O clock otherwise runs.
  wire       io_run    = !asleep || in_idle;
  wire [3:0] gate_bits = clock_gate_control_q[3:0];
  wire       conv_gate = gate_bits[GATE_CONVERTER_POS];

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sleep_mode_control_q <= REG_RESET;
      core_control_q       <= REG_RESET;
      clock_gate_control_q <= REG_RESET;
      state_q              <= ST_RUN;
      extended_q           <= 1'b0;
      conv_gate_prev_q     <= 1'b0;
    end else begin
      state_q          <= state_d;
      conv_gate_prev_q <= conv_gate;
      if (wr_sleep) sleep_mode_control_q <= link.reg_wdata & SLEEP_MODE_MASK;
      if (wr_gate)  clock_gate_control_q <= link.reg_wdata & CLOCK_GATE_MASK;
      if (wr_core) begin
        core_control_q[SCAN_PORT_DISABLE_POS] <= link.reg_wdata[SCAN_PORT_DISABLE_POS];
        core_control_q[BROWNOUT_UNLOCK_POS]   <= link.reg_wdata[BROWNOUT_UNLOCK_POS];
      end
      if (brownout_set) begin
        core_control_q[BROWNOUT_OFF_POS] <= 1'b1;
      end else if (brownout_done) begin
        core_control_q[BROWNOUT_OFF_POS] <= 1'b0;
      end
      if (!unlock_busy && !unlock_req) core_control_q[BROWNOUT_UNLOCK_POS] <= 1'b0;
      // Re-enable after a gate sets the extended flag, which then holds until reset.
      if (conv_gate_prev_q && !conv_gate) begin
        extended_q <= 1'b1;
      end else if (!converter_enabled_in) begin
        extended_q <= extended_q;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      module_clock_en_q      <= '0;
      module_access_en_q     <= '0;
      io_clock_en_q          <= 1'b0;
      converter_clock_en_q   <= 1'b0;
      main_osc_en_q          <= 1'b0;
      input_buffer_en_q      <= 1'b0;
      comparator_mux_allow_q <= 1'b0;
      comparator_off_q       <= 1'b0;
      brownout_off_q         <= 1'b0;
      scan_port_en_q         <= 1'b0;
      reg_rdata_q            <= REG_RESET;
      cpu_halted_q           <= 1'b0;
      sleeping_q             <= 1'b0;
    end else begin
      module_clock_en_q      <= io_run ? ~gate_bits : 4'h0;
      module_access_en_q     <= ~gate_bits;
      io_clock_en_q          <= !asleep || in_idle;
      converter_clock_en_q   <= (!asleep || in_idle || in_nrm) || converter_enabled_in;
      main_osc_en_q          <= !deep || (sleep_mode_select == MODE_STANDBY) ||
                                (pd_or_ps && debug_enable_fuse_in && scan_on);
      input_buffer_en_q      <= !(deep && !converter_enabled_in);
      comparator_mux_allow_q <= !conv_gate;
      comparator_off_q       <= deep && !comparator_uses_ref_in;
      brownout_off_q         <= asleep && brownout_busy ? 1'b1 :
                                (asleep ? brownout_off_q : 1'b0);
      scan_port_en_q         <= scan_on;
      reg_rdata_q            <= rdata_d;
      cpu_halted_q           <= (state_d != ST_RUN);
      sleeping_q             <= (state_d == ST_SLEEP);
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================
  assign module_clock_en_out      = module_clock_en_q;
  assign module_access_en_out     = module_access_en_q;
  assign io_clock_en_out          = io_clock_en_q;
  assign converter_clock_en_out   = converter_clock_en_q;
  assign main_osc_en_out          = main_osc_en_q;
  assign input_buffer_en_out      = input_buffer_en_q;
  assign comparator_mux_allow_out = comparator_mux_allow_q;
  assign comparator_off_out       = comparator_off_q;
  assign brownout_off_out         = brownout_off_q;
  assign scan_port_en_out         = scan_port_en_q;
  assign converter_extended_out   = extended_q;
  assign link.reg_rdata           = reg_rdata_q;
  assign link.cpu_halted          = cpu_halted_q;
  assign link.sleeping            = sleeping_q;
endmodule

// ===== verilog/power_mgmt_host.sv
`timescale 1ns/1ps
module power_mgmt_host (
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Link to device.
  power_mgmt_if.host       link
);
  import power_mgmt_pkg::*;

  // ==========================================================================
  // Decode.
  // ==========================================================================
  logic        reg_write_q;
  logic [1:0]  reg_sel_q;
  logic [7:0]  reg_wdata_q;
  logic        sleep_instr_q;
  logic        wake_event_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        wait_q;

  // One wait cycle lets the registered link read data follow a new select.
  wire access   = psel && penable && wait_q && !pready_q;
  wire hit_reg  = (paddr == APB_SLEEP_MODE) || (paddr == APB_CORE_CTRL) ||
                  (paddr == APB_CLOCK_GATE);
  wire hit_cmd  = (paddr == APB_COMMAND);
  wire hit_stat = (paddr == APB_STATUS);
  wire mapped   = hit_reg || hit_cmd || hit_stat;
  wire [1:0] sel_d = (paddr == APB_CORE_CTRL)  ? REG_CORE_CONTROL :
                     (paddr == APB_CLOCK_GATE) ? REG_CLOCK_GATE_CONTROL :
                     REG_SLEEP_MODE_CONTROL;
  // Link read data is registered, so the select is driven during setup.
  wire [31:0] rdata_d = hit_reg  ? {24'h000000, link.reg_rdata} :
                        hit_stat ? {30'h00000000, link.sleeping, link.cpu_halted} :
                        32'h00000000;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_write_q   <= 1'b0;
      reg_sel_q     <= REG_SLEEP_MODE_CONTROL;
      reg_wdata_q   <= 8'h00;
      sleep_instr_q <= 1'b0;
      wake_event_q  <= 1'b0;
      pready_q      <= 1'b0;
      prdata_q      <= 32'h00000000;
      pslverr_q     <= 1'b0;
      wait_q        <= 1'b0;
    end else begin
      wait_q        <= psel && penable && !pready_q;
      if (psel && hit_reg) reg_sel_q <= sel_d;
      reg_write_q   <= access && pwrite && hit_reg;
      reg_wdata_q   <= pwdata[7:0];
      sleep_instr_q <= access && pwrite && hit_cmd && pwdata[CMD_SLEEP_POS];
      wake_event_q  <= access && pwrite && hit_cmd && pwdata[CMD_WAKE_POS];
      pready_q      <= access;
      prdata_q      <= (access && !pwrite) ? rdata_d : 32'h00000000;
      pslverr_q     <= access && !mapped;
    end
  end

  assign pready           = pready_q;
  assign prdata           = prdata_q;
  assign pslverr          = pslverr_q;
  assign link.reg_write   = reg_write_q;
  assign link.reg_sel     = reg_sel_q;
  assign link.reg_wdata   = reg_wdata_q;
  assign link.sleep_instr = sleep_instr_q;
  assign link.wake_event  = wake_event_q;
endmodule

// ===== tb/power_mgmt_checker.sv
`timescale 1ns/1ps
module power_mgmt_checker (
  input wire logic       clk_sys_in,
  input wire logic       rst_in,
  input wire logic       reg_write,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       sleep_instr,
  input wire logic       wake_event,
  input wire logic       cpu_halted,
  input wire logic       sleeping
);
  import power_mgmt_pkg::*;
  // ==========================================================================
  // Shadow registers.
  // ==========================================================================
  logic [7:0] smc_q;
  logic [7:0] gate_q;
  logic [1:0] sel_q;
  logic [2:0] brownout_sleep_off_q;
  logic       wr_q;
  wire        ok_mode = smc_q[3:1] inside {MODE_IDLE, MODE_NOISE_RED, MODE_POWER_DOWN,
                                           MODE_POWER_SAVE, MODE_STANDBY};
  wire        wr_smc  = reg_write && reg_sel == REG_SLEEP_MODE_CONTROL;
  wire        wr_gate = reg_write && reg_sel == REG_CLOCK_GATE_CONTROL;
  wire        brownout_sleep_off_rd = sel_q == REG_CORE_CONTROL && reg_rdata[BROWNOUT_OFF_POS];
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      smc_q  <= 8'h00;
      gate_q <= 8'h00;
      brownout_sleep_off_q <= 3'h0;
    end else begin
      smc_q  <= wr_smc ? reg_wdata : smc_q;
      gate_q <= wr_gate ? reg_wdata : gate_q;
      brownout_sleep_off_q <= brownout_sleep_off_rd ? brownout_sleep_off_q + 3'h1 : 3'h0;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    sel_q <= reg_sel;
    wr_q  <= reg_write;
  end
  // ==========================================================================
  // Properties.
  // ==========================================================================
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  chk_sleep_enter: assert property (sleep_instr && smc_q[0] && ok_mode && !sleeping
    && !cpu_halted |=> sleeping) else $error("sleep not entered");
  chk_sleep_noop: assert property (sleep_instr && !smc_q[0] && !sleeping |=> !sleeping)
    else $error("sleep taken with enable clear");
  chk_reserved_mode: assert property (sleep_instr && !ok_mode && !sleeping |=> !sleeping)
    else $error("reserved mode entered");
  chk_sleep_cause: assert property ($rose(sleeping) |-> $past(sleep_instr))
    else $error("sleep without instruction");
  chk_wake_hold: assert property ($fell(cpu_halted) |-> $past(cpu_halted, 2)
    && $past(cpu_halted, 3) && $past(cpu_halted, 4)) else $error("halt too short");
  chk_gate_upper: assert property (reg_sel == REG_CLOCK_GATE_CONTROL
    |=> reg_rdata[7:4] == 4'h0) else $error("gate upper bits set");
  chk_gate_read: assert property (reg_sel == REG_CLOCK_GATE_CONTROL && !reg_write && !wr_q
    |=> reg_rdata == (gate_q & CLOCK_GATE_MASK)) else $error("gate readback wrong");
  chk_mode_read: assert property (reg_sel == REG_SLEEP_MODE_CONTROL && !reg_write && !wr_q
    |=> reg_rdata == (smc_q & SLEEP_MODE_MASK)) else $error("mode readback wrong");
  chk_brownout_life: assert property (brownout_sleep_off_q <= 3'h3)
    else $error("brown-out bit held too long");
endmodule

// ===== tb/power_mgmt_control_tb.sv
`timescale 1ns/1ps
module power_mgmt_control_tb;
  import power_mgmt_pkg::*;
  logic clk_sys_in, rst_in, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic dbg_f, scan_f, conv_en, cmp_ref, startup_done_in;
  logic [3:0] clk_en, acc_en;
  logic io_en, conv_clk, osc_en, buf_en, mux_ok, cmp_off, bo_off, scan_en, conv_ext;
  int failures, n_tests;
  power_mgmt_if link_if ();
  power_mgmt_host power_mgmt_host_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .link(link_if));
  power_mgmt_control power_mgmt_control_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .link(link_if), .debug_enable_fuse_in(dbg_f), .scan_port_enable_fuse_in(scan_f),
    .converter_enabled_in(conv_en), .comparator_uses_ref_in(cmp_ref),
    .startup_done_in(startup_done_in), .module_clock_en_out(clk_en),
    .module_access_en_out(acc_en), .io_clock_en_out(io_en), .converter_clock_en_out(conv_clk),
    .main_osc_en_out(osc_en), .input_buffer_en_out(buf_en), .comparator_mux_allow_out(mux_ok),
    .comparator_off_out(cmp_off), .brownout_off_out(bo_off), .scan_port_en_out(scan_en),
    .converter_extended_out(conv_ext));
  power_mgmt_checker power_mgmt_checker_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .reg_write(link_if.reg_write), .reg_sel(link_if.reg_sel), .reg_wdata(link_if.reg_wdata),
    .reg_rdata(link_if.reg_rdata), .sleep_instr(link_if.sleep_instr),
    .wake_event(link_if.wake_event), .cpu_halted(link_if.cpu_halted),
    .sleeping(link_if.sleeping));
  // ==========================================================================
  // Bus and report tasks.
  // ==========================================================================
  task automatic results();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  // Keeping psel high chains a back-to-back setup, which the unlock window needs.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic keep);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      results();
    end
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
    if (!keep) begin
      psel <= 1'b0;
      @(posedge clk_sys_in);
    end
  endtask
  task automatic go_sleep(input logic [2:0] md, input logic se);
    apb(1'b1, APB_SLEEP_MODE, {28'h0, md, se}, 1'b1);
    apb(1'b1, APB_COMMAND, 32'h1, 1'b1);
    apb(1'b0, APB_STATUS, 32'h0, 1'b0);
  endtask
  task automatic wake();
    int n;
    n = 0;
    startup_done_in <= 1'b0;
    apb(1'b1, APB_COMMAND, 32'h2, 1'b1);
    apb(1'b0, APB_STATUS, 32'h0, 1'b0);
    check(rd[0], 1'b1);
    startup_done_in <= 1'b1;
    do begin
      apb(1'b0, APB_STATUS, 32'h0, 1'b0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    check(rd[1:0], 2'h0);
    apb(1'b1, APB_SLEEP_MODE, 32'h0, 1'b0);
  endtask
  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic t_reset();
    apb(1'b0, APB_SLEEP_MODE, 32'h0, 1'b0);
    check(rd, REG_RESET);
    check(clk_en, 4'hF);
    check(acc_en, 4'hF);
    apb(1'b0, 8'h20, 32'h0, 1'b0);
    check(er, 1'b1);
    check(rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_gate();
    conv_en <= 1'b0;
    apb(1'b1, APB_CLOCK_GATE, 32'hFF, 1'b1);
    apb(1'b0, APB_CLOCK_GATE, 32'h0, 1'b0);
    check(rd, 32'h0F);
    check({clk_en, acc_en, mux_ok}, 9'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, APB_CLOCK_GATE, 32'h1 << i, 1'b1);
      apb(1'b0, APB_CLOCK_GATE, 32'h0, 1'b0);
      check({clk_en, acc_en}, {2{4'hF ^ (4'h1 << i)}});
    end
    apb(1'b1, APB_CLOCK_GATE, 32'h0, 1'b1);
    apb(1'b0, APB_CLOCK_GATE, 32'h0, 1'b0);
    check({clk_en, mux_ok, conv_ext}, 6'h3F);
    $display("test gate done");
  endtask
  task automatic t_sleep();
    logic [2:0] m [8] = '{MODE_IDLE, MODE_NOISE_RED, MODE_POWER_DOWN, MODE_POWER_SAVE,
                          MODE_STANDBY, 3'h4, 3'h5, 3'h7};
    apb(1'b1, APB_CLOCK_GATE, 32'h2, 1'b0);
    for (int i = 0; i < 8; i++) begin
      conv_en <= i[0];
      go_sleep(m[i], 1'b1);
      check(rd[1:0], {2{i < 5}});
      if (i < 5) begin
        check({io_en, conv_clk, buf_en}, {i == 0, i < 2 || i[0], i < 2 || i[0]});
        check(cmp_off, i > 1);
        if (i != 1) check(clk_en, i == 0 ? 4'hD : 4'h0);
        if (i < 4) check(osc_en, i < 2);
        wake();
      end
    end
    go_sleep(MODE_POWER_DOWN, 1'b0);
    check({rd[1:0], io_en}, 3'h1);
    apb(1'b1, APB_CLOCK_GATE, 32'h0, 1'b0);
    $display("test sleep done");
  endtask
  task automatic t_core();
    apb(1'b1, APB_CORE_CTRL, 32'h40, 1'b1);
    apb(1'b0, APB_CORE_CTRL, 32'h0, 1'b0);
    check(rd, 32'h0);
    apb(1'b1, APB_CORE_CTRL, 32'h60, 1'b1);
    apb(1'b1, APB_CORE_CTRL, 32'h40, 1'b1);
    apb(1'b0, APB_CORE_CTRL, 32'h0, 1'b1);
    check(rd[6], 1'b1);
    apb(1'b0, APB_CORE_CTRL, 32'h0, 1'b0);
    check({rd[6], bo_off}, 2'h0);
    dbg_f <= 1'b1;
    apb(1'b1, APB_CORE_CTRL, 32'h80, 1'b1);
    apb(1'b0, APB_CORE_CTRL, 32'h0, 1'b0);
    check({rd, scan_en}, {32'h80, 1'b0});
    apb(1'b0, APB_SLEEP_MODE, 32'h0, 1'b0);
    check(rd, 32'h4);
    go_sleep(MODE_POWER_DOWN, 1'b1);
    check(osc_en, 1'b0);
    wake();
    apb(1'b1, APB_CORE_CTRL, 32'h0, 1'b1);
    apb(1'b0, APB_CORE_CTRL, 32'h0, 1'b0);
    check({rd, scan_en}, {32'h0, 1'b1});
    cmp_ref <= 1'b1;
    go_sleep(MODE_POWER_SAVE, 1'b1);
    check({osc_en, cmp_off}, 2'h2);
    wake();
    scan_f <= 1'b0;
    apb(1'b0, APB_STATUS, 32'h0, 1'b0);
    check(scan_en, 1'b0);
    $display("test core done");
  endtask
  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    {rst_in, psel, penable, pwrite, paddr, pwdata} = {3'h4, 1'b0, 8'h00, 32'h0};
    {dbg_f, scan_f, conv_en, cmp_ref, startup_done_in} = 5'h09;
    failures = 0;
    n_tests = 0;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_gate();
    t_sleep();
    t_core();
    results();
  end
endmodule
